// [core/cbt_bit_timer.sv]
// Bit segment sequencer with resynchronisation and sampling
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module cbt_bit_timer (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire logic       tq_tick_i,
  input  wire logic [3:0] ts1_i,
  input  wire logic [2:0] ts2_i,
  input  wire logic [1:0] resync_jump_width_i,
  input  wire logic       triple_i,
  input  wire logic       rx_i,
  output logic            bit_start_o,
  output logic            sample_o,
  output logic            bit_value_o
);
  typedef enum logic [2:0] {
    ph_sync = 3'b001,
    ph_seg1 = 3'b010,
    ph_seg2 = 3'b100
  } cbt_phase_e;

  typedef struct packed {
    cbt_phase_e phase;
    logic [4:0] q;
    logic [4:0] len;
    logic [2:0] hist;
    logic       rx_prev;
    logic       resynced;
    logic       start_p;
    logic       sample_p;
    logic       bit_val;
  } cbt_bt_s;

  cbt_bt_s    s;
  cbt_bt_s    next_s;
  logic [4:0] jump;
  logic [4:0] pe;
  logic [4:0] len_v;
  logic [4:0] remain;
  logic [2:0] hist_v;
  logic       edge_f;
  logic [4:0] h_cnt;
  logic [4:0] h_last;

  function automatic logic majority(input logic [2:0] h);
    return (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
  endfunction : majority

  always_comb begin
    jump   = {3'b000, resync_jump_width_i} + 5'h01;
    pe     = s.q + 5'h01;
    remain = s.len - s.q - 5'h01;
    hist_v = {s.hist[1:0], rx_i};
    edge_f = s.rx_prev & ~rx_i & ~s.resynced;
    len_v  = s.len;
    next_s = s;
    if (ce_i) begin
      next_s.start_p  = 1'b0;
      next_s.sample_p = 1'b0;
      if (!run_i) begin
        next_s.phase    = ph_sync;
        next_s.q        = 5'h00;
        next_s.resynced = 1'b0;
      end else if (tq_tick_i) begin
        next_s.rx_prev = rx_i;
        next_s.hist    = hist_v;
        case (s.phase)
          ph_sync: begin
            next_s.start_p  = 1'b1;
            next_s.phase    = ph_seg1;
            next_s.q        = 5'h00;
            next_s.len      = {1'b0, ts1_i} + 5'h01;
            next_s.resynced = s.rx_prev & ~rx_i;
          end
          ph_seg1: begin
            // Late edge: stretch by the phase error, no more than the jump
            if (edge_f) begin
              len_v           = s.len + ((pe < jump) ? pe : jump);
              next_s.len      = len_v;
              next_s.resynced = 1'b1;
            end
            if (pe >= len_v) begin
              next_s.sample_p = 1'b1;
              next_s.bit_val  = triple_i ? majority(hist_v) : rx_i;
              next_s.phase    = ph_seg2;
              next_s.q        = 5'h00;
              next_s.len      = {2'b00, ts2_i} + 5'h01;
            end else begin
              next_s.q = pe;
            end
          end
          ph_seg2: begin
            // Early edge: the next bit has begun, cut this one short
            if (edge_f && remain <= jump) begin
              next_s.start_p  = 1'b1;
              next_s.phase    = ph_seg1;
              next_s.q        = 5'h00;
              next_s.len      = {1'b0, ts1_i} + 5'h01;
              next_s.resynced = 1'b1;
            end else begin
              if (edge_f) begin
                len_v           = s.len - jump;
                next_s.len      = len_v;
                next_s.resynced = 1'b1;
              end
              if (pe >= len_v) begin
                next_s.phase = ph_sync;
                next_s.q     = 5'h00;
              end else begin
                next_s.q = pe;
              end
            end
          end
          default: begin
            next_s.phase = ph_sync;
            next_s.q     = 5'h00;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s         <= '0;
      s.phase   <= ph_sync;
      s.hist    <= 3'b111;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bit_start_o = s.start_p;
  assign sample_o    = s.sample_p;
  assign bit_value_o = s.bit_val;

  // Quanta spent in the segment just left
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      h_cnt  <= 5'h00;
      h_last <= 5'h00;
    end else if (ce_i && run_i && tq_tick_i) begin
      if (next_s.phase != s.phase || next_s.start_p) begin
        h_cnt  <= 5'h00;
        h_last <= h_cnt + 5'h01;
      end else begin
        h_cnt <= h_cnt + 5'h01;
      end
    end
  end

  property p_sync_one_tq;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      run_i && tq_tick_i && s.phase == ph_sync |=> s.phase == ph_seg1 && s.start_p;
  endproperty
  a_sync_one_tq: assert property (p_sync_one_tq)
    else $error("sync segment did not last exactly one quantum");

  property p_seg1_len;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      s.sample_p && run_i |-> h_last >= {1'b0, ts1_i} + 5'h01
        && h_last <= {1'b0, ts1_i} + {3'b000, resync_jump_width_i} + 5'h02;
  endproperty
  a_seg1_len: assert property (p_seg1_len)
    else $error("before-sample segment length out of range");

  property p_seg2_len;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      // A restart also lands in sync; h_last then belongs to another segment
      run_i && $past(run_i) && $rose(s.phase == ph_sync)
        |-> h_last <= {2'b00, ts2_i} + 5'h01;
  endproperty
  a_seg2_len: assert property (p_seg2_len)
    else $error("after-sample segment longer than programmed");

  property p_vote;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      s.sample_p |-> s.bit_val == (triple_i ? majority(s.hist) : s.hist[0]);
  endproperty
  a_vote: assert property (p_vote)
    else $error("sampled bit value does not match the vote");
endmodule : cbt_bit_timer

// [core/cbt_pkg.sv]
// Shared constants for the CAN bit-timing configuration block
package cbt_pkg;
  // Clock rates: bus clock of this block and the timing reference clock
  localparam int unsigned SYS_CLK_HZ    = 100_000_000;
  localparam int unsigned REF_CLK_HZ    = 16_000_000;
  localparam logic [26:0] ACC_SYS       = 27'(SYS_CLK_HZ);
  localparam logic [26:0] ACC_REF       = 27'(REF_CLK_HZ);

  // Register byte offsets
  localparam logic [3:0]  OFS_PRESCALE  = 4'h0;
  localparam logic [3:0]  OFS_SEGMENTS  = 4'h4;
  localparam logic [3:0]  OFS_CTRL      = 4'h8;
  localparam logic [3:0]  OFS_STATUS    = 4'hc;

  // Field positions in the two timing bytes
  localparam int          PRE_JUMP_MSB  = 7;
  localparam int          PRE_JUMP_LSB  = 6;
  localparam int          PRE_QDIV_MSB  = 5;
  localparam int          SEG_VOTE_BIT  = 7;
  localparam int          SEG_TS2_MSB   = 6;
  localparam int          SEG_TS2_LSB   = 4;
  localparam int          SEG_TS1_MSB   = 3;

  // Control and status fields
  localparam int          CTRL_INIT_BIT = 0;
  localparam int          CTRL_STOP_BIT = 1;
  localparam int          STAT_RUN_BIT  = 0;
  localparam int          STAT_BIT_BIT  = 1;
  localparam int          STAT_ERR_MSB  = 15;
  localparam int          STAT_ERR_LSB  = 8;

  // Reset values and codes
  localparam logic [7:0]  PRESCALE_RST  = 8'h00;
  localparam logic [7:0]  SEGMENTS_RST  = 8'h00;
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  BAD_RATE_CODE = 8'h47;

  // Accepted timing byte pairs, first byte in the upper half
  localparam int          NUM_RATES     = 9;
  localparam logic [15:0] RATE_TABLE [NUM_RATES] = '{
    16'h672f, 16'h532f, 16'h472f, 16'h432f, 16'h031c,
    16'h011c, 16'h001c, 16'h0016, 16'h0014
  };
endpackage : cbt_pkg

// [core/cbt_quantum_gen.sv]
// Time-quantum tick generator from a fractional 16 MHz reference
`timescale 1ns/1ps
module cbt_quantum_gen (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire logic [5:0] quantum_prescale_i,
  output logic            tq_tick_o
);
  typedef struct packed {
    logic [26:0] acc;
    logic [6:0]  rcnt;
    logic        tick;
  } cbt_qgen_s;

  cbt_qgen_s   s;
  cbt_qgen_s   next_s;
  logic [26:0] sum;
  logic        ref_tick;
  logic [6:0]  term;
  logic [7:0]  h_refs;

  // Reference edges average 16 MHz; jitter of one sys cycle is the price
  // of not needing a second clock.
  always_comb begin
    sum      = s.acc + cbt_pkg::ACC_REF;
    ref_tick = (sum >= cbt_pkg::ACC_SYS);
    term     = {quantum_prescale_i, 1'b1};
    next_s   = s;
    if (ce_i) begin
      next_s.tick = 1'b0;
      if (!run_i) begin
        next_s.acc  = 27'h000_0000;
        next_s.rcnt = 7'h00;
      end else begin
        next_s.acc = ref_tick ? (sum - cbt_pkg::ACC_SYS) : sum;
        if (ref_tick) begin
          if (s.rcnt == term) begin
            next_s.rcnt = 7'h00;
            next_s.tick = 1'b1;
          end else begin
            next_s.rcnt = s.rcnt + 7'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tq_tick_o = s.tick;

  // Reference edges since the previous quantum
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      h_refs <= 8'h00;
    end else if (ce_i) begin
      if (!run_i || s.tick) begin
        h_refs <= {7'h00, run_i & ref_tick};
      end else if (ref_tick) begin
        h_refs <= h_refs + 8'h01;
      end
    end
  end

  property p_quantum_len;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      s.tick && run_i |-> h_refs == ({1'b0, quantum_prescale_i, 1'b0} + 8'h02);
  endproperty
  a_quantum_len: assert property (p_quantum_len)
    else $error("quantum is not two reference periods times prescale plus one");
endmodule : cbt_quantum_gen

// [core/cbt_top.sv]
// CAN bit-timing configuration block with Avalon-MM register slave
`timescale 1ns/1ps
module cbt_top (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        can_rx_i,
  output logic             bit_start_o,
  output logic             sample_o,
  output logic             bit_value_o,
  output logic             running_o
);
  typedef struct packed {
    logic [7:0]  prescale;
    logic [7:0]  segments;
    logic [7:0]  act_pre;
    logic [7:0]  act_seg;
    logic        running;
    logic        restart;
    logic [7:0]  err_code;
    logic        waitreq;
    logic [31:0] rdata;
  } cbt_top_s;

  cbt_top_s    s;
  cbt_top_s    next_s;
  logic [31:0] rd_v;
  logic        take_wr;
  logic        wr_init;
  logic        wr_stop;
  logic        init_ok;
  logic        tq_tick;
  logic        core_run;

  function automatic logic rate_ok(input logic [15:0] pair);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < cbt_pkg::NUM_RATES; i++) begin
      if (cbt_pkg::RATE_TABLE[i] == pair) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction : rate_ok

  // Write lands only on the edge where waitrequest is seen low
  assign take_wr = avs_write_i & ~s.waitreq & avs_byteenable_i[0];
  assign wr_init = take_wr && avs_address_i == cbt_pkg::OFS_CTRL
                   && avs_writedata_i[cbt_pkg::CTRL_INIT_BIT];
  assign wr_stop = take_wr && avs_address_i == cbt_pkg::OFS_CTRL
                   && avs_writedata_i[cbt_pkg::CTRL_STOP_BIT];
  assign init_ok = rate_ok({s.prescale, s.segments});

  always_comb begin
    rd_v = 32'h0000_0000;
    case (avs_address_i)
      cbt_pkg::OFS_PRESCALE: rd_v[7:0] = s.prescale;
      cbt_pkg::OFS_SEGMENTS: rd_v[7:0] = s.segments;
      cbt_pkg::OFS_STATUS: begin
        rd_v[cbt_pkg::STAT_RUN_BIT]                      = s.running;
        rd_v[cbt_pkg::STAT_BIT_BIT]                      = bit_value_o;
        rd_v[cbt_pkg::STAT_ERR_MSB:cbt_pkg::STAT_ERR_LSB] = s.err_code;
      end
      default: rd_v = 32'h0000_0000;
    endcase

    next_s = s;
    if (ce_i) begin
      next_s.waitreq = 1'b1;
      next_s.restart = 1'b0;
      // One wait cycle per access; read data is latched with the answer
      if ((avs_read_i || avs_write_i) && s.waitreq) begin
        next_s.waitreq = 1'b0;
        next_s.rdata   = avs_read_i ? rd_v : 32'h0000_0000;
      end
      if (take_wr) begin
        case (avs_address_i)
          cbt_pkg::OFS_PRESCALE: next_s.prescale = avs_writedata_i[7:0];
          cbt_pkg::OFS_SEGMENTS: next_s.segments = avs_writedata_i[7:0];
          default: ;
        endcase
      end
      // New timing only reaches the sequencer through a checked init
      if (wr_init) begin
        if (init_ok) begin
          next_s.act_pre  = s.prescale;
          next_s.act_seg  = s.segments;
          next_s.running  = 1'b1;
          next_s.restart  = 1'b1;
          next_s.err_code = cbt_pkg::ERR_NONE;
        end else begin
          next_s.running  = 1'b0;
          next_s.err_code = cbt_pkg::BAD_RATE_CODE;
        end
      end else if (wr_stop) begin
        next_s.running = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.prescale <= cbt_pkg::PRESCALE_RST;
      s.segments <= cbt_pkg::SEGMENTS_RST;
      s.err_code <= cbt_pkg::ERR_NONE;
      s.waitreq  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Restart pulse realigns quanta and bit phase after a re-init
  assign core_run = s.running & ~s.restart;

  cbt_quantum_gen u_qgen (
    .sys_clk_i          (sys_clk_i),
    .rst_i              (rst_i),
    .ce_i               (ce_i),
    .run_i              (core_run),
    .quantum_prescale_i (s.act_pre[cbt_pkg::PRE_QDIV_MSB:0]),
    .tq_tick_o          (tq_tick)
  );

  cbt_bit_timer u_bits (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .ce_i                (ce_i),
    .run_i               (core_run),
    .tq_tick_i           (tq_tick),
    .ts1_i               (s.act_seg[cbt_pkg::SEG_TS1_MSB:0]),
    .ts2_i               (s.act_seg[cbt_pkg::SEG_TS2_MSB:cbt_pkg::SEG_TS2_LSB]),
    .resync_jump_width_i (s.act_pre[cbt_pkg::PRE_JUMP_MSB:cbt_pkg::PRE_JUMP_LSB]),
    .triple_i            (s.act_seg[cbt_pkg::SEG_VOTE_BIT]),
    .rx_i                (can_rx_i),
    .bit_start_o         (bit_start_o),
    .sample_o            (sample_o),
    .bit_value_o         (bit_value_o)
  );

  assign avs_readdata_o    = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign running_o         = s.running;

  property p_wait_answer;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      (avs_read_i || avs_write_i) && s.waitreq |=> !s.waitreq ##1 s.waitreq;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("bus access not answered after one wait cycle");

  property p_bad_rate;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      wr_init && !init_ok |=> s.err_code == cbt_pkg::BAD_RATE_CODE && !s.running;
  endproperty
  a_bad_rate: assert property (p_bad_rate)
    else $error("invalid timing pair was not refused");

  property p_good_init;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      wr_init && init_ok |=> s.running && s.act_pre == $past(s.prescale)
        && s.act_seg == $past(s.segments) && s.err_code == cbt_pkg::ERR_NONE;
  endproperty
  a_good_init: assert property (p_good_init)
    else $error("valid timing pair was not applied");

  property p_read_prescale;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      avs_read_i && s.waitreq && avs_address_i == cbt_pkg::OFS_PRESCALE
        |=> s.rdata == {24'h00_0000, $past(s.prescale)};
  endproperty
  a_read_prescale: assert property (p_read_prescale)
    else $error("prescale byte readback wrong");

  property p_read_segments;
    @(posedge sys_clk_i) disable iff (rst_i || !ce_i)
      avs_read_i && s.waitreq && avs_address_i == cbt_pkg::OFS_SEGMENTS
        |=> s.rdata == {24'h00_0000, $past(s.segments)};
  endproperty
  a_read_segments: assert property (p_read_segments)
    else $error("segment byte readback wrong");
endmodule : cbt_top

// [tb/cbt_bus_node.sv]
// Far bus node model driving the receive level seen by the block
`timescale 1ns/1ps
module cbt_bus_node (
  input  wire logic       sys_clk_i,
  input  wire logic       dominant_i,
  input  wire logic [3:0] lag_i,
  output logic            can_rx_o
);
  logic [15:0] hist;

  // Lag models a distant node; released bus is pulled recessive
  always_ff @(posedge sys_clk_i) begin
    hist <= {hist[14:0], dominant_i};
  end

  always_comb begin
    if (lag_i == 4'h0) begin
      can_rx_o = ~dominant_i;
    end else begin
      can_rx_o = ~hist[lag_i - 4'h1];
    end
  end
endmodule : cbt_bus_node

// [tb/tb_top.sv]
// Self-checking bench for the bit-timing block
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic        rd_req  = 1'b0;
  logic        wr_req  = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  be      = 4'hf;
  logic        dom     = 1'b0;
  logic        ce      = 1'b1;
  logic [3:0]  lag     = 4'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic        rx;
  logic        bstart;
  logic        samp;
  logic        bval;
  logic        running;
  int          failures    = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  cbt_top dut_u (
    .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .avs_address_i(addr),
    .avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .can_rx_i(rx), .bit_start_o(bstart), .sample_o(samp), .bit_value_o(bval),
    .running_o(running)
  );

  cbt_bus_node node_u (.sys_clk_i(sys_clk), .dominant_i(dom), .lag_i(lag), .can_rx_o(rx));

  task close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task check_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      failures++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  // Request held until waitrequest is seen low at a rising edge
  task av(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    rd_req <= ~we;
    wr_req <= we;
    addr   <= a;
    wdata  <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    if (n >= 50) begin
      failures++;
      $display("Error waitrequest expected 0 seen timeout");
      close_out();
    end
  endtask : av

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask : wr

  task rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0000_0000, q);
    check(what, exp, q);
  endtask : rdchk

  task wait_hi(input bit smp, output int t);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      if ((smp ? samp : bstart) === 1'b1) break;
    end
    t = cyc;
    if (n >= 3000) begin
      failures++;
      $display("Error pulse expected seen timeout");
      close_out();
    end
  endtask : wait_hi

  task init(input logic [15:0] pair);
    wr(4'h0, {24'h00_0000, pair[15:8]});
    wr(4'h4, {24'h00_0000, pair[7:0]});
    wr(4'h8, 32'h0000_0001);
  endtask : init

  task t_reset;
    rdchk("prescale", 4'h0, 32'h0000_0000);
    rdchk("segments", 4'h4, 32'h0000_0000);
    rdchk("ctrl", 4'h8, 32'h0000_0000);
    rdchk("status", 4'hc, 32'h0000_0000);
    rdchk("unmapped", 4'h2, 32'h0000_0000);
    check("running", 32'(1'b0), 32'(running));
  endtask : t_reset

  task t_fields;
    wr(4'h0, 32'hffff_ffc5);
    rdchk("prescale", 4'h0, 32'h0000_00c5);
    wr(4'h4, 32'hffff_ffa7);
    rdchk("segments", 4'h4, 32'h0000_00a7);
    be <= 4'he;
    wr(4'h0, 32'h0000_0011);
    be <= 4'hf;
    rdchk("prescale lane", 4'h0, 32'h0000_00c5);
    wr(4'h8, 32'h0000_0001);
    rdchk("status bad", 4'hc, 32'h0000_4700);
    check("running bad", 32'(1'b0), 32'(running));
    wr(4'h8, 32'h0000_0002);
    rdchk("status stop", 4'hc, 32'h0000_4700);
  endtask : t_fields

  task t_rates;
    logic [15:0] tbl [9];
    logic [31:0] q;
    tbl = '{16'h672f, 16'h532f, 16'h472f, 16'h432f, 16'h031c,
            16'h011c, 16'h001c, 16'h0016, 16'h0014};
    foreach (tbl[i]) begin
      init(tbl[i]);
      av(1'b0, 4'hc, 32'h0000_0000, q);
      check("status ok", 32'h0000_0001, q & 32'hffff_fffd);
      check("running ok", 32'(1'b1), 32'(running));
    end
  endtask : t_rates

  // Two quanta are 4*(brp+1) reference periods, i.e. 25*(brp+1) cycles
  task t_timing(input logic [15:0] pair);
    int ta;
    int ts;
    int tb;
    int q2;
    int bit_cyc;
    q2 = 25 * (int'(pair[13:8]) + 1);
    bit_cyc = (3 + int'(pair[3:0]) + int'(pair[6:4])) * q2 / 2;
    init(pair);
    wait_hi(1'b0, ta);
    wait_hi(1'b0, ta);
    wait_hi(1'b1, ts);
    wait_hi(1'b0, tb);
    check_rng("bit period", bit_cyc - 3, bit_cyc + 3, tb - ta);
    // Start pulse follows the sync quantum, so after-sample plus one sync quantum
    check_rng("after sample", (int'(pair[6:4]) + 2) * q2 / 2 - 3,
              (int'(pair[6:4]) + 2) * q2 / 2 + 3, tb - ts);
  endtask : t_timing

  // Late edge in the before-sample segment; jump width one quantum
  task t_resync;
    int t0;
    int t1;
    logic [31:0] q;
    init(16'h0014);
    lag <= 4'h2;
    wait_hi(1'b0, t0);
    wait_hi(1'b0, t0);
    repeat (30) @(posedge sys_clk);
    dom <= 1'b1;
    wait_hi(1'b0, t1);
    check_rng("resync period", 110, 116, t1 - t0);
    repeat (3) wait_hi(1'b1, t1);
    @(posedge sys_clk);
    check("bit value dominant", 32'(1'b0), 32'(bval));
    av(1'b0, 4'hc, 32'h0000_0000, q);
    check("status bit", 32'(1'b0), 32'(q[1]));
    dom <= 1'b0;
    repeat (2) wait_hi(1'b1, t1);
    @(posedge sys_clk);
    check("bit value recessive", 32'(1'b1), 32'(bval));
  endtask : t_resync

  // Edge right after the sample point; jump width one quantum cuts the bit
  task t_early;
    int ts;
    int tb;
    dom <= 1'b0;
    repeat (3) wait_hi(1'b1, ts);
    dom <= 1'b1;
    wait_hi(1'b0, tb);
    check_rng("early edge start", 10, 16, tb - ts);
    wait_hi(1'b1, ts);
    @(posedge sys_clk);
    check("bit value early", 32'(1'b0), 32'(bval));
    dom <= 1'b0;
  endtask : t_early

  // Enable low must hold every pulse and the quantum phase still
  task t_freeze;
    int ts;
    int t;
    int seen;
    seen = 0;
    wait_hi(1'b1, ts);
    ce <= 1'b0;
    repeat (200) begin
      @(posedge sys_clk);
      if (bstart !== 1'b0 || samp !== 1'b0) seen++;
    end
    check("frozen pulses", 32'h0000_0000, 32'(seen));
    check("frozen running", 32'(1'b1), 32'(running));
    ce <= 1'b1;
    wait_hi(1'b0, t);
    check_rng("frozen start", 233, 242, t - ts);
  endtask : t_freeze

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_rates();
    t_timing(16'h0014);
    t_timing(16'h031c);
    t_resync();
    t_early();
    t_freeze();
    close_out();
  end
endmodule : tb_top
